// *** core/adc_pkg.sv ***
package adc_pkg;

	// clock and ready-pulse timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RDY_PULSE_NS = 1000;
	localparam int RDY_PULSE_CYC = (RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register selector values
	localparam logic [1:0] PTR_RESULT = 2'h0;
	localparam logic [1:0] PTR_SETUP = 2'h1;
	localparam logic [1:0] PTR_LOWER = 2'h2;
	localparam logic [1:0] PTR_UPPER = 2'h3;

	// reset values
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] SETUP_RESET = 16'h8583;
	localparam logic [15:0] LOWER_RESET = 16'h8000;
	localparam logic [15:0] UPPER_RESET = 16'h7fff;

	// converter_setup field positions
	localparam int CSS_BIT = 15;
	localparam int IPS_HI = 14;
	localparam int IPS_LO = 12;
	localparam int GRS_HI = 11;
	localparam int GRS_LO = 9;
	localparam int MODE_BIT = 8;
	localparam int SRS_HI = 7;
	localparam int SRS_LO = 5;
	localparam int WSTYLE_BIT = 4;
	localparam int WPOL_BIT = 3;
	localparam int WLAT_BIT = 2;
	localparam int WQUE_HI = 1;
	localparam int WQUE_LO = 0;
	localparam int SIGN_BIT = 15;

	// queue codes and the matching conversion counts
	localparam logic [1:0] QUE_ONE = 2'h0;
	localparam logic [1:0] QUE_TWO = 2'h1;
	localparam logic [1:0] QUE_OFF = 2'h3;
	localparam logic [2:0] QNEED_ONE = 3'h1;
	localparam logic [2:0] QNEED_TWO = 3'h2;
	localparam logic [2:0] QNEED_FOUR = 3'h4;

	// serial bus addresses and commands
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h48;
	localparam logic [7:0] GC_RESET_CMD = 8'h06;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// serial slave states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_RX = 3'b011,
		ST_TX = 3'b100,
		ST_MACK = 3'b101
	} bus_state_t;

endpackage : adc_pkg

// *** core/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 2
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [W-1:0] pin_in, // asynchronous pins
	output logic [W-1:0] pin_out // synchronised copy
);

	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} sync_t;

	sync_t sync_r;
	sync_t sync_nxt;

	// first stage feeds only the second stage
	always_comb begin
		sync_nxt.stage1 = pin_in;
		sync_nxt.stage2 = sync_r.stage1;
	end

	// idle bus level is high
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync_r <= '1;
		end else begin
			sync_r <= sync_nxt;
		end
	end

	assign pin_out = sync_r.stage2;

endmodule : pin_sync

// *** core/limit_check.sv ***
`timescale 1ns/1ps
module limit_check (
	input wire logic [15:0] sample, // new conversion result
	input wire logic [15:0] upper, // upper limit, two's complement
	input wire logic [15:0] lower, // lower limit, two's complement
	input wire logic window_style, // 1 selects window comparison
	output logic exceed, // result counts toward the queue
	output logic back_in // result allows a non-latched clear
);

	// signed digital compare of raw codes
	always_comb begin
		if (window_style) begin
			exceed = ($signed(sample) > $signed(upper)) || ($signed(sample) < $signed(lower));
			back_in = !exceed;
		end else begin
			exceed = $signed(sample) > $signed(upper);
			back_in = $signed(sample) < $signed(lower);
		end
	end

endmodule : limit_check

// *** core/adc_threshold_core.sv ***
`timescale 1ns/1ps
// Function
// - start bit write accepted only in power-down; 1 starts one conversion, 0 ignored.
// - start/status bit reads 0 while converting and 1 when idle.
// - bits 14:12 choose the converter input pair, default 000.
// - bits 11:9 choose the full-scale span, default 010.
// - bit 8 selects continuous (0) or single-shot power-down (1), reset 1.
// - bits 7:5 choose the sample rate, default code 100.
// - bit 4 selects traditional (0) or window (1) comparison.
// - bit 3 makes the alert output active low (0) or high (1).
// - non-latched alert clears on a result below the lower limit, or back inside the limits in window mode.
// - latched alert holds until data read or won alert response.
// - queue code 11 disables the comparator and holds the output high.
// - queue codes 00, 01, 10 need one, two or four exceeding results.
// - limits are 16-bit two's complement, compared digitally with results.
// - upper sign 1 with lower sign 0 turns the output into ready.
// - ready follows status in single-shot, pulses per result in continuous.
// - the device never drives the serial clock line.
// - the result register ignores host writes.
// - two-bit selector picks result, setup, lower or upper register.
// - result reads zero after reset until the first conversion ends.
// - general-call command 06h resets all registers and enters power-down.
// - 16-bit values move high byte first, then low byte.
module adc_threshold_core import adc_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
	parameter int RDY_CYC = RDY_PULSE_CYC
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic scl_in, // serial clock pin, input only
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // serial data drive value, always 0
	output logic sda_oe_n, // serial data enable, low pulls line low
	input wire logic conv_done, // converter pulse: result ready
	input wire logic [15:0] conv_data, // converter result, two's complement
	output logic conv_run, // converter enable level
	output logic [2:0] input_pair_select, // input pair code to the converter
	output logic [2:0] gain_range_select, // full-scale span code
	output logic [2:0] sample_rate_select, // sample rate code
	output logic alert_pin // alert/ready output level
);

	typedef struct packed {
		logic scl_q;
		logic sda_q;
		bus_state_t st;
		logic [3:0] bit_cnt;
		logic [7:0] shreg;
		logic [1:0] byte_idx;
		logic rw;
		logic gc;
		logic ara;
		logic [1:0] ptr;
		logic [7:0] wr_hi;
		logic sda_oe_n;
		logic sda_out;
		logic [14:0] setup;
		logic [15:0] lower;
		logic [15:0] upper;
		logic [15:0] result;
		logic busy;
		logic conv_run;
		logic [2:0] q_cnt;
		logic alert_act;
		logic [15:0] rdy_cnt;
		logic alert_pin;
	} state_t;

	localparam state_t RESET_ST = '{
		scl_q: 1'b1,
		sda_q: 1'b1,
		st: ST_IDLE,
		sda_oe_n: 1'b1,
		setup: SETUP_RESET[14:0],
		lower: LOWER_RESET,
		upper: UPPER_RESET,
		result: RESULT_RESET,
		alert_pin: 1'b1,
		default: '0
	};

	state_t state_r;
	state_t state_nxt;
	logic scl_s;
	logic sda_s;
	logic exceed;
	logic back_in;

	// register readback, status bit live from the busy flag
	function automatic logic [15:0] read_reg(input logic [1:0] p, input state_t s);
		case (p)
			PTR_RESULT: read_reg = s.result;
			PTR_SETUP: read_reg = {!s.busy, s.setup};
			PTR_LOWER: read_reg = s.lower;
			default: read_reg = s.upper;
		endcase
	endfunction : read_reg

	// number of exceeding results needed per queue code
	function automatic logic [2:0] queue_need(input logic [1:0] q);
		case (q)
			QUE_ONE: queue_need = QNEED_ONE;
			QUE_TWO: queue_need = QNEED_TWO;
			default: queue_need = QNEED_FOUR;
		endcase
	endfunction : queue_need

	// bus pins cross into the system clock domain
	pin_sync #(
		.W(2)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in({scl_in, sda_in}),
		.pin_out({scl_s, sda_s})
	);

	// limit comparison on the incoming result
	limit_check u_limit (
		.sample(conv_data),
		.upper(state_r.upper),
		.lower(state_r.lower),
		.window_style(state_r.setup[WSTYLE_BIT]),
		.exceed(exceed),
		.back_in(back_in)
	);

	// next-state logic: serial slave, registers, conversion control, alert
	always_comb begin
		logic scl_rise;
		logic scl_fall;
		logic start_c;
		logic stop_c;
		logic load_tx;
		logic gc_reset;
		logic read_clear;
		logic setup_write;
		logic mode_single;
		logic latch;
		logic rdy_mode;
		logic asserted;
		logic done_ok;
		logic [15:0] rd_word;
		logic [15:0] wr_word;
		logic [7:0] tx;
		logic [2:0] q_next;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_c = 1'b0;
		stop_c = 1'b0;
		load_tx = 1'b0;
		gc_reset = 1'b0;
		read_clear = 1'b0;
		setup_write = 1'b0;
		mode_single = state_r.setup[MODE_BIT];
		latch = state_r.setup[WLAT_BIT];
		rdy_mode = state_r.upper[SIGN_BIT] && !state_r.lower[SIGN_BIT];
		asserted = 1'b0;
		done_ok = conv_done && state_r.conv_run;
		rd_word = read_reg(state_r.ptr, state_r);
		wr_word = {state_r.wr_hi, state_r.shreg};
		tx = 8'h00;
		q_next = state_r.q_cnt;
		state_nxt = state_r;

		// edge and start/stop detection on synchronised pins
		state_nxt.scl_q = scl_s;
		state_nxt.sda_q = sda_s;
		scl_rise = scl_s && !state_r.scl_q;
		scl_fall = !scl_s && state_r.scl_q;
		start_c = scl_s && state_r.scl_q && state_r.sda_q && !sda_s;
		stop_c = scl_s && state_r.scl_q && !state_r.sda_q && sda_s;

		// serial slave; only the data line is ever driven
		if (start_c) begin
			state_nxt.st = ST_ADDR;
			state_nxt.bit_cnt = 4'h0;
			state_nxt.byte_idx = 2'h0;
			state_nxt.gc = 1'b0;
			state_nxt.ara = 1'b0;
			state_nxt.sda_oe_n = 1'b1;
		end else if (stop_c) begin
			state_nxt.st = ST_IDLE;
			state_nxt.sda_oe_n = 1'b1;
		end else begin
			case (state_r.st)
				ST_ADDR, ST_RX: begin
					if (scl_rise && state_r.bit_cnt != BITS_PER_BYTE) begin
						state_nxt.shreg = {state_r.shreg[6:0], sda_s};
						state_nxt.bit_cnt = state_r.bit_cnt + 4'h1;
					end else if (scl_fall && state_r.bit_cnt == BITS_PER_BYTE) begin
						state_nxt.st = ST_ACK;
						state_nxt.sda_oe_n = 1'b0; // acknowledge the byte
						if (state_r.st == ST_ADDR) begin
							state_nxt.rw = state_r.shreg[0];
							state_nxt.gc = (state_r.shreg[7:1] == GEN_CALL_ADDR) && !state_r.shreg[0];
							state_nxt.ara = (state_r.shreg[7:1] == ALERT_RESP_ADDR) && state_r.shreg[0]
								&& state_r.alert_act && latch;
							if (!((state_r.shreg[7:1] == DEV_ADDR) || state_nxt.gc || state_nxt.ara)) begin
								state_nxt.st = ST_IDLE;
								state_nxt.sda_oe_n = 1'b1;
							end
						end else if (state_r.gc) begin
							gc_reset = state_r.shreg == GC_RESET_CMD;
						end else begin
							case (state_r.byte_idx)
								2'h0: state_nxt.ptr = state_r.shreg[1:0];
								2'h1: state_nxt.wr_hi = state_r.shreg;
								2'h2: begin
									case (state_r.ptr)
										PTR_SETUP: setup_write = 1'b1;
										PTR_LOWER: state_nxt.lower = wr_word;
										PTR_UPPER: state_nxt.upper = wr_word;
										default: ; // result is read-only
									endcase
								end
								default: ;
							endcase
							if (state_r.byte_idx != 2'h3) begin
								state_nxt.byte_idx = state_r.byte_idx + 2'h1;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (state_r.rw) begin
							load_tx = 1'b1;
						end else begin
							state_nxt.st = ST_RX;
							state_nxt.bit_cnt = 4'h0;
							state_nxt.sda_oe_n = 1'b1;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						state_nxt.bit_cnt = state_r.bit_cnt + 4'h1;
						// lost alert-response arbitration to a lower address
						if (state_r.ara && state_r.sda_oe_n && !sda_s) begin
							state_nxt.st = ST_IDLE;
						end
					end else if (scl_fall) begin
						if (state_r.bit_cnt == BITS_PER_BYTE) begin
							state_nxt.st = ST_MACK;
							state_nxt.sda_oe_n = 1'b1;
							read_clear = state_r.ara;
						end else begin
							state_nxt.shreg = {state_r.shreg[6:0], 1'b0};
							state_nxt.sda_oe_n = state_r.shreg[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise && sda_s) begin
						state_nxt.st = ST_IDLE; // host ended the read
					end else if (scl_fall) begin
						load_tx = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// load the next byte to transmit, high byte first
		if (load_tx) begin
			if (state_r.ara) begin
				tx = {DEV_ADDR, 1'b0};
			end else if (state_r.byte_idx == 2'h0) begin
				tx = rd_word[15:8];
				read_clear = state_r.ptr == PTR_RESULT;
			end else begin
				tx = rd_word[7:0];
			end
			state_nxt.st = ST_TX;
			state_nxt.bit_cnt = 4'h0;
			state_nxt.shreg = tx;
			state_nxt.sda_oe_n = tx[7];
			state_nxt.byte_idx = 2'h1;
		end

		// setup write; all input-pair codes stored as written
		if (setup_write) begin
			state_nxt.setup = wr_word[14:0];
			if (wr_word[CSS_BIT] && mode_single && !state_r.busy) begin
				state_nxt.busy = 1'b1;
				state_nxt.conv_run = 1'b1;
			end
		end

		// finished conversion updates the result
		if (done_ok) begin
			state_nxt.result = conv_data;
			if (mode_single) begin
				state_nxt.busy = 1'b0;
				state_nxt.conv_run = 1'b0;
			end
		end

		// continuous mode keeps the converter running
		if (!state_nxt.setup[MODE_BIT]) begin
			state_nxt.busy = 1'b1;
			state_nxt.conv_run = 1'b1;
		end

		// comparator queue; a new trip wins over a read clear
		if (read_clear && latch) begin
			state_nxt.alert_act = 1'b0;
		end
		if (state_r.setup[WQUE_HI:WQUE_LO] == QUE_OFF) begin
			state_nxt.q_cnt = 3'h0;
			state_nxt.alert_act = 1'b0;
		end else if (done_ok && !rdy_mode) begin
			if (exceed) begin
				q_next = (state_r.q_cnt < QNEED_FOUR) ? state_r.q_cnt + 3'h1 : state_r.q_cnt;
				state_nxt.q_cnt = q_next;
				if (q_next >= queue_need(state_r.setup[WQUE_HI:WQUE_LO])) begin
					state_nxt.alert_act = 1'b1;
				end
			end else begin
				state_nxt.q_cnt = 3'h0;
				if (!latch && back_in) begin
					state_nxt.alert_act = 1'b0;
				end
			end
		end

		// ready pulse timer for continuous mode
		if (state_r.rdy_cnt != 16'h0000) begin
			state_nxt.rdy_cnt = state_r.rdy_cnt - 16'h0001;
		end
		if (done_ok && rdy_mode && !mode_single) begin
			state_nxt.rdy_cnt = 16'(RDY_CYC);
		end

		// output pin: ready or alert, polarity, disable
		if (rdy_mode) begin
			asserted = mode_single ? !state_r.busy : (state_r.rdy_cnt != 16'h0000);
		end else begin
			asserted = state_r.alert_act;
		end
		if (state_r.setup[WQUE_HI:WQUE_LO] == QUE_OFF) begin
			state_nxt.alert_pin = 1'b1;
		end else begin
			state_nxt.alert_pin = state_r.setup[WPOL_BIT] ? asserted : !asserted;
		end

		// general-call reset returns registers and powers down
		if (gc_reset) begin
			state_nxt.setup = RESET_ST.setup;
			state_nxt.lower = RESET_ST.lower;
			state_nxt.upper = RESET_ST.upper;
			state_nxt.result = RESET_ST.result;
			state_nxt.ptr = PTR_RESULT;
			state_nxt.busy = 1'b0;
			state_nxt.conv_run = 1'b0;
			state_nxt.q_cnt = 3'h0;
			state_nxt.alert_act = 1'b0;
			state_nxt.rdy_cnt = 16'h0000;
		end

		state_nxt.sda_out = 1'b0; // open drain: drive value is always low
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= RESET_ST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// outputs straight from the state register; no clock line output
	assign sda_out = state_r.sda_out;
	assign sda_oe_n = state_r.sda_oe_n;
	assign conv_run = state_r.conv_run;
	assign input_pair_select = state_r.setup[IPS_HI:IPS_LO];
	assign gain_range_select = state_r.setup[GRS_HI:GRS_LO];
	assign sample_rate_select = state_r.setup[SRS_HI:SRS_LO];
	assign alert_pin = state_r.alert_pin;

endmodule : adc_threshold_core

// *** tb/adc_alert_checker_assertions.sv ***
`timescale 1ns/1ps
// watches the pins of the threshold core for cause and timing
module adc_alert_checker import adc_pkg::*; #(
	parameter int RDY_CYC = RDY_PULSE_CYC
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset
	input wire logic scl_in, // serial clock pin
	input wire logic sda_in, // serial data wire
	input wire logic sda_out, // data drive value
	input wire logic sda_oe_n, // data pull enable
	input wire logic conv_done, // result strobe
	input wire logic [15:0] conv_data, // converter result
	input wire logic conv_run, // converter enable
	input wire logic [2:0] input_pair_select, // pair code
	input wire logic [2:0] gain_range_select, // span code
	input wire logic [2:0] sample_rate_select, // rate code
	input wire logic alert_pin // alert/ready level
);
	logic [4:0] idle_r;
	logic [4:0] idle_nxt;
	int dn_r;
	int dn_nxt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// cycles with the clock line high, and cycles since the last result
	always_comb begin
		idle_nxt = !scl_in ? 5'h00 : (idle_r == 5'h1f ? idle_r : idle_r + 5'h01);
		dn_nxt = conv_done ? 0 : (dn_r > 1000 ? dn_r : dn_r + 1);
	end
	always_ff @(posedge clk_sys) begin
		idle_r <= rst ? 5'h00 : idle_nxt;
		dn_r <= rst ? 1001 : dn_nxt;
	end
	a_reset_pins: assert property ($fell(rst) |-> alert_pin && !conv_run && sda_oe_n
		&& {input_pair_select, gain_range_select, sample_rate_select} == 9'h014)
		else $error("pins not at reset state");
	a_sel_at_fall: assert property (!$stable({input_pair_select, gain_range_select,
		sample_rate_select}) |-> !$past(scl_in, 2)) else $error("select moved off a clock fall");
	a_run_start: assert property ($rose(conv_run) |-> !$past(scl_in, 2))
		else $error("converter started without a write");
	a_run_stop: assert property ($fell(conv_run) |->
		$past(conv_done) || $past(conv_done, 2) || !$past(scl_in, 2))
		else $error("converter stopped without cause");
	a_drive_at_fall: assert property (!$stable(sda_oe_n) |-> !$past(scl_in, 2))
		else $error("data drive changed while clock high");
	a_idle_release: assert property (idle_r >= 5'h10 |-> sda_oe_n)
		else $error("data held low on an idle bus");
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("data drive value not low");
	a_alert_cause: assert property (!$stable(alert_pin) |->
		!$past(scl_in, 2) || dn_r <= RDY_CYC + 4) else $error("alert moved without cause");
	c_result: cover property (conv_done && conv_run);
	c_alert: cover property ($fell(alert_pin));
	c_ack: cover property ($fell(sda_oe_n));
endmodule : adc_alert_checker

bind adc_threshold_core adc_alert_checker #(.RDY_CYC(RDY_CYC)) chk_u (
	.clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .conv_done(conv_done), .conv_data(conv_data), .conv_run(conv_run),
	.input_pair_select(input_pair_select), .gain_range_select(gain_range_select),
	.sample_rate_select(sample_rate_select), .alert_pin(alert_pin));

// *** tb/bus_host_model.sv ***
`timescale 1ns/1ps
// serial bus host: sole driver of the clock, releases data to the pull-up
module bus_host_model import adc_pkg::*; (
	input wire logic clk_sys, // pacing clock
	input wire logic sda_line, // resolved data wire
	output logic scl, // serial clock, idles high
	output logic sda_drv // data drive, 1 releases
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : w
	// one 80 ns clock pulse; data moves mid low phase, sampled before the fall
	task automatic bit_io(input logic b, output logic r);
		w(2);
		sda_drv = b;
		w(2);
		scl = 1'b1;
		w(4);
		r = sda_line;
		scl = 1'b0;
	endtask : bit_io
	task automatic start_c();
		w(4);
		sda_drv = 1'b1;
		w(2);
		scl = 1'b1;
		w(4);
		sda_drv = 1'b0;
		w(4);
		scl = 1'b0;
	endtask : start_c
	task automatic stop_c();
		w(4);
		sda_drv = 1'b0;
		w(2);
		scl = 1'b1;
		w(4);
		sda_drv = 1'b1;
		w(4);
	endtask : stop_c
	// byte out msb first; ok is the device acknowledge
	task automatic tx(input logic [7:0] d, output logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ok = !r;
	endtask : tx
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask : rx
	// register write: pointer, then high byte, then low byte
	task automatic wr(input logic [1:0] p, input logic [15:0] v, output logic ok);
		logic [3:0] a;
		start_c();
		tx({DEV_ADDR_DEFAULT, 1'b0}, a[0]);
		tx({6'h00, p}, a[1]);
		tx(v[15:8], a[2]);
		tx(v[7:0], a[3]);
		stop_c();
		ok = &a;
	endtask : wr
	// pointer write, repeated start, two-byte read ended by a nack
	task automatic rd(input logic [1:0] p, output logic [15:0] v, output logic ok);
		logic [2:0] a;
		start_c();
		tx({DEV_ADDR_DEFAULT, 1'b0}, a[0]);
		tx({6'h00, p}, a[1]);
		start_c();
		tx({DEV_ADDR_DEFAULT, 1'b1}, a[2]);
		rx(1'b0, v[15:8]);
		rx(1'b1, v[7:0]);
		stop_c();
		ok = &a;
	endtask : rd
	// alert response read: one address byte back, ended by a nack
	task automatic alert_resp(output logic [7:0] d, output logic ok);
		start_c();
		tx({ALERT_RESP_ADDR, 1'b1}, ok);
		rx(1'b1, d);
		stop_c();
	endtask : alert_resp
	task automatic gc(output logic ok);
		logic [1:0] a;
		start_c();
		tx({GEN_CALL_ADDR, 1'b0}, a[0]);
		tx(GC_RESET_CMD, a[1]);
		stop_c();
		ok = &a;
	endtask : gc
endmodule : bus_host_model

// *** tb/adc_config_and_threshold_alert_tb_top.sv ***
`timescale 1ns/1ps
module adc_config_and_threshold_alert_tb_top import adc_pkg::*;;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic conv_done = 1'b0;
	logic [15:0] conv_data = 16'h0000;
	logic scl, sda_drv, sda_out, sda_oe_n, conv_run, alert_pin, ok, seen;
	logic [2:0] ips, grs, srs;
	logic [15:0] v, lo;
	wire sda_line;
	integer seed = 32'he50c;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	// open-drain data wire with pull-up
	assign sda_line = sda_drv & (sda_oe_n | sda_out);
	always #5 clk_sys = ~clk_sys;
	adc_threshold_core #(.RDY_CYC(4)) dut_u (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_done(conv_done),
		.conv_data(conv_data), .conv_run(conv_run), .input_pair_select(ips),
		.gain_range_select(grs), .sample_rate_select(srs), .alert_pin(alert_pin));
	bus_host_model host_u (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t word %h expected %h", $time, g, e);
		end
	endtask : chk_word
	task automatic chk_bit(input logic g, input logic e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t bit %b expected %b", $time, g, e);
		end
	endtask : chk_bit
	// setup word with default pair, span and rate
	function automatic logic [15:0] cfg(input logic st, md, win, pol, lat, input logic [1:0] q);
		return {st, 3'h0, 3'h2, md, 3'h4, win, pol, lat, q};
	endfunction : cfg
	task automatic wreg(input logic [1:0] p, input logic [15:0] d);
		host_u.wr(p, d, ok);
		chk_bit(ok, 1'b1);
	endtask : wreg
	task automatic rchk(input logic [1:0] p, input logic [15:0] e);
		host_u.rd(p, v, ok);
		chk_bit(ok, 1'b1);
		chk_word(v, e);
	endtask : rchk
	// one converter result, then let the pin settle
	task automatic conv(input logic [15:0] d);
		@(negedge clk_sys);
		conv_data = d;
		conv_done = 1'b1;
		@(negedge clk_sys);
		conv_done = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask : conv
	initial begin
		repeat (6) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		// reset state of pins and registers, then a dropped result write
		chk_bit(alert_pin, 1'b1);
		chk_word({7'h00, ips, grs, srs}, 16'h0014);
		rchk(PTR_RESULT, RESULT_RESET);
		rchk(PTR_SETUP, SETUP_RESET);
		rchk(PTR_LOWER, LOWER_RESET);
		rchk(PTR_UPPER, UPPER_RESET);
		wreg(PTR_RESULT, 16'h1234);
		rchk(PTR_RESULT, RESULT_RESET);
		// random upper limit and setup fields; first pass uses all-ones codes
		for (int i = 0; i < 3; i++) begin
			lo = 16'($random(seed));
			wreg(PTR_UPPER, lo);
			rchk(PTR_UPPER, lo);
			v = 16'($random(seed));
			v = {1'b0, v[14:9], 1'b1, v[7:2], 2'b11};
			if (i == 0) v = 16'h7fe3;
			lo = v;
			wreg(PTR_SETUP, lo);
			chk_word({7'h00, ips, grs, srs}, {7'h00, lo[14:9], lo[7:5]});
			rchk(PTR_SETUP, {1'b1, lo[14:0]});
		end
		// single shot: busy while converting, result lands, back to power-down
		wreg(PTR_SETUP, cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, QUE_OFF));
		chk_bit(conv_run, 1'b1);
		rchk(PTR_SETUP, cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, QUE_OFF));
		lo = 16'($random(seed));
		conv(lo);
		chk_bit(conv_run, 1'b0);
		rchk(PTR_RESULT, lo);
		rchk(PTR_SETUP, cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, QUE_OFF));
		// limits rewritten after the span change, upper above lower
		wreg(PTR_LOWER, 16'h0100);
		wreg(PTR_UPPER, 16'h1000);
		// queue codes need one, two or four results above the upper limit
		for (int q = 0; q < 3; q++) begin
			wreg(PTR_SETUP, cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, q[1:0]));
			conv(16'h0000);
			for (int k = 1; k <= (1 << q); k++) begin
				conv(16'h2000);
				chk_bit(alert_pin, k < (1 << q));
			end
		end
		conv(16'h0800);
		chk_bit(alert_pin, 1'b0);
		conv(16'hff00);
		chk_bit(alert_pin, 1'b1);
		// latched alert: response refused while quiet, cleared by a result read or a response
		wreg(PTR_SETUP, cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, QUE_ONE));
		host_u.alert_resp(v[7:0], ok);
		chk_bit(ok, 1'b0);
		conv(16'h2000);
		conv(16'h0000);
		chk_bit(alert_pin, 1'b0);
		rchk(PTR_RESULT, 16'h0000);
		chk_bit(alert_pin, 1'b1);
		conv(16'h2000);
		chk_bit(alert_pin, 1'b0);
		host_u.alert_resp(v[7:0], ok);
		chk_bit(ok, 1'b1);
		chk_word({8'h00, v[7:0]}, {8'h00, DEV_ADDR_DEFAULT, 1'b0});
		chk_bit(alert_pin, 1'b1);
		// window style, active high
		wreg(PTR_SETUP, cfg(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, QUE_ONE));
		conv(16'h0050);
		chk_bit(alert_pin, 1'b1);
		conv(16'h0800);
		chk_bit(alert_pin, 1'b0);
		wreg(PTR_SETUP, cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, QUE_OFF));
		conv(16'h7000);
		chk_bit(alert_pin, 1'b1);
		// ready use: follows status in single shot, pulses in continuous
		wreg(PTR_UPPER, 16'h8000);
		wreg(PTR_LOWER, 16'h0000);
		wreg(PTR_SETUP, cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, QUE_ONE));
		// the conversion left running by continuous mode must end before power-down
		conv(16'h0000);
		chk_bit(alert_pin, 1'b0);
		wreg(PTR_SETUP, cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, QUE_ONE));
		chk_bit(alert_pin, 1'b1);
		conv(16'h4321);
		chk_bit(alert_pin, 1'b0);
		wreg(PTR_SETUP, cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, QUE_ONE));
		seen = 1'b0;
		@(negedge clk_sys);
		conv_done = 1'b1;
		@(negedge clk_sys);
		conv_done = 1'b0;
		repeat (20) begin
			@(negedge clk_sys);
			if (alert_pin === 1'b0) seen = 1'b1;
		end
		chk_bit(seen, 1'b1);
		chk_bit(alert_pin, 1'b1);
		// general-call reset back to power-down defaults
		host_u.gc(ok);
		chk_bit(ok, 1'b1);
		chk_bit(conv_run, 1'b0);
		rchk(PTR_SETUP, SETUP_RESET);
		rchk(PTR_UPPER, UPPER_RESET);
		report_and_stop();
	end
endmodule : adc_config_and_threshold_alert_tb_top
